// ==== dv/codec_pll_adc_bridge_regs_tb.sv ====
/*
 Self-checking bench for the codec register bank, against a mirror model.
 Assumes host_model drives the strobes; UNIT_CYCLES is shortened to 4.
*/
`timescale 1ns/1ps
module codec_pll_adc_bridge_regs_tb;
   import codec_regs_pkg::*;
   localparam int UNIT = 4;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        reg_write, reg_read, reg_rvalid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, general_config_out;
   logic        pll_locked = 1'b1, modulator_invalid = 1'b0, modulator_muted = 1'b0;
   logic        bridge_pdown = 1'b0, bridge_tristate, pll_bypass;
   logic [3:0]  bridge_fault_in = 4'h0, pop_guard;
   logic        bitclock_as_reference, synth_power_down, adc_input_select, adc_standby;
   logic        adc_dc_bypass, adc_clock_gate, clock_out_disable, modulator_source_select;
   logic [2:0]  adc_gain_select, modulator_rate_band;
   logic [1:0]  output_clock_divider, converter_rate_band;
   logic [15:0] driver_word;
   logic [7:0]  mirror [0:255];
   logic [7:0]  addrs [12] = '{8'h18, 8'h1e, 8'h1f, 8'h20, 8'h2d, 8'h2e, 8'h05, 8'h06,
                               8'h19, 8'h23, 8'h32, 8'h40};
   logic [7:0]  masks [12] = '{8'hfe, 8'hfe, 8'he0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                               8'h00, 8'h00, 8'h00, 8'h00};
   int          mismatches = 0;
   int          checks_done = 0;

   codec_pll_adc_bridge_regs #(.UNIT_CYCLES(UNIT)) i_dut (
      .clk(clk), .resetn(resetn), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pll_locked(pll_locked),
      .modulator_invalid(modulator_invalid), .modulator_muted(modulator_muted),
      .bridge_pdown(bridge_pdown), .bridge_fault_in(bridge_fault_in),
      .pll_bypass(pll_bypass), .bitclock_as_reference(bitclock_as_reference),
      .synth_power_down(synth_power_down), .pop_guard(pop_guard),
      .adc_gain_select(adc_gain_select), .adc_input_select(adc_input_select),
      .adc_standby(adc_standby), .adc_dc_bypass(adc_dc_bypass),
      .adc_clock_gate(adc_clock_gate), .clock_out_disable(clock_out_disable),
      .output_clock_divider(output_clock_divider), .modulator_rate_band(modulator_rate_band),
      .converter_rate_band(converter_rate_band),
      .modulator_source_select(modulator_source_select),
      .general_config_out(general_config_out), .driver_word(driver_word),
      .bridge_tristate(bridge_tristate));

   host_model i_host (
      .clk(clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Live status as the mirror predicts; bridge faults handled separately
   function automatic logic [7:0] exp_read(input logic [7:0] a);
      logic [7:0] pf;
      pf = mirror[8'h18];
      case (a)
         8'h19:   exp_read = {~pll_locked, pf[5], pf[7] & ~pll_locked, 5'h00};
         8'h23:   exp_read = {5'h00, modulator_invalid, modulator_muted, 1'b0};
         8'h32:   exp_read = {bridge_pdown, 7'h00};
         default: exp_read = mirror[a];
      endcase
   endfunction

   task automatic read_all();
      logic [7:0] d;
      foreach (addrs[k]) begin
         i_host.rd(addrs[k], d);
         check(16'(d), 16'(exp_read(addrs[k])));
      end
   endtask

   task automatic check_outputs();
      logic [7:0] pf, ac, ck, gc;
      pf = mirror[8'h18];
      ac = mirror[8'h1e];
      ck = mirror[8'h1f];
      gc = mirror[8'h20];
      check(16'(pll_bypass), 16'(pf[7] & ~pll_locked));
      check(16'({bitclock_as_reference, synth_power_down}), 16'(pf[6:5]));
      check(16'(pop_guard), 16'(pf[4:1]));
      check(16'({adc_gain_select, adc_input_select}), 16'(ac[7:4]));
      check(16'({adc_standby, adc_dc_bypass, adc_clock_gate}), 16'(ac[3:1]));
      check(16'({clock_out_disable, output_clock_divider}), 16'(ck[7:5]));
      check(16'({modulator_rate_band, converter_rate_band}), 16'(gc[6:2]));
      check(16'({modulator_source_select, general_config_out}), {7'h0, gc[1], gc});
      check(driver_word, {mirror[8'h2d], mirror[8'h2e]});
   endtask

   initial begin
      logic [7:0] d;
      int         k;
      void'($urandom(32'ha354));
      foreach (mirror[a]) mirror[a] = 8'h00;
      mirror[8'h1e] = 8'h02;
      mirror[8'h20] = 8'h20;
      mirror[8'h06] = 8'h02;
      repeat (5) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      read_all();
      check_outputs();
      for (int i = 0; i < 24; i++) begin
         k = $urandom_range(11);
         d = 8'($urandom);
         i_host.wr(addrs[k], d);
         mirror[addrs[k]] = d & masks[k];
         #1 {pll_locked, modulator_invalid, modulator_muted, bridge_pdown} = 4'($urandom);
         repeat (6) @(posedge clk);
         read_all();
         check_outputs();
      end
      bridge_pdown = 1'b0;
      // Random loop may have left a large high byte in the fault time
      i_host.wr(8'h05, 8'h00);
      mirror[8'h05] = 8'h00;
      i_host.wr(8'h06, 8'h08);
      mirror[8'h06] = 8'h08;
      #1 bridge_fault_in = 4'b0100;
      repeat (6) @(posedge clk);
      i_host.rd(8'h32, d);
      check(16'(d), 16'h0050);
      i_host.wr(8'h18, mirror[8'h18] | 8'h01);
      i_host.rd(8'h32, d);
      check(16'(d), 16'h0050);
      #1 bridge_fault_in = 4'b0000;
      repeat (6) @(posedge clk);
      i_host.rd(8'h32, d);
      check(16'(d), 16'h0050);
      i_host.wr(8'h18, mirror[8'h18] | 8'h01);
      repeat (60) @(posedge clk);
      i_host.rd(8'h32, d);
      check(16'(d), 16'h0000);
      #1 bridge_fault_in = 4'b1000;
      repeat (2) @(posedge clk);
      #1 bridge_fault_in = 4'b0000;
      repeat (5) @(posedge clk);
      i_host.wr(8'h18, mirror[8'h18] | 8'h01);
      // Latch is gone; only the hold timer (8 units of 4 cycles) keeps tristate
      check(16'(bridge_tristate), 16'h0001);
      repeat (40) @(posedge clk);
      check(16'(bridge_tristate), 16'h0000);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule

// ==== dv/host_model.sv ====
/*
 Host-side model: issues one-cycle register write and read strobes.
 Assumes its tasks are called from one bench process at a time.
*/
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk,
   output logic            reg_write,
   output logic            reg_read,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_write = 1'b0;
      reg_read  = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Host acknowledges a fault by writing bit 0 through this same task
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clk);
      #1;
      reg_write = 1'b0;
      // Idle bus shows inverted values so nothing stale looks valid
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clk);
      #1;
      // Answer settles just after the sampling edge; take it before release
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
      reg_read = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

// ==== rtl/codec_pll_adc_bridge_regs.sv ====
/*
 Configuration and status register bank of the codec: PLL, ADC, clock
 output, modulator and power bridge. Assumes the serial control
 interface has already decoded accesses into a one-cycle read or write
 strobe with an 8-bit address and data, all on clk.
*/
// What this block does
// RULE_01: Bypass PLL while unlocked if enabled
// RULE_02: Bit clock feeds PLL reference when set
// RULE_03: Power down PLL when set
// RULE_04: Connect pop guard resistors per output
// RULE_05: Writing one clears latched bridge faults
// RULE_06: Status reports PLL out of lock
// RULE_07: Status reports PLL power-down and bypass
// RULE_08: Three-bit ADC gain, 6 dB steps
// RULE_09: Input select picks microphone input
// RULE_10: Standby bit powers ADC down
// RULE_11: Clock gate bit delivers ADC clock
// RULE_12: Clock out divides PLL by power of two
// RULE_13: Modulator rate band field
// RULE_14: Converter rate band field
// RULE_15: Modulator source is ADC or serial
// RULE_16: Modulator invalid input and mute flags
// RULE_17: Driver word split across two registers
// RULE_18: Bridge power-down and tristate flags
// RULE_19: Per half-bridge fault flags
// RULE_20: Tristate hold after fault for programmed time
// RULE_21: Reserved bits read zero, ignore writes
// RULE_22: Status reads are live, side-effect free
`timescale 1ns/1ps
module codec_pll_adc_bridge_regs #(
   parameter int UNIT_CYCLES = codec_regs_pkg::FAULT_UNIT_CYCLES
) (
   input  wire logic                                clk,
   input  wire logic                                resetn,
   input  wire logic                                reg_write,
   input  wire logic                                reg_read,
   input  wire logic [codec_regs_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [codec_regs_pkg::DATA_W-1:0]   reg_wdata,
   output logic      [codec_regs_pkg::DATA_W-1:0]   reg_rdata,
   output logic                                     reg_rvalid,
   input  wire logic                                pll_locked,
   input  wire logic                                modulator_invalid,
   input  wire logic                                modulator_muted,
   input  wire logic                                bridge_pdown,
   input  wire logic [3:0]                          bridge_fault_in,
   output logic                                     pll_bypass,
   output logic                                     bitclock_as_reference,
   output logic                                     synth_power_down,
   output logic [3:0]                               pop_guard,
   output logic [2:0]                               adc_gain_select,
   output logic                                     adc_input_select,
   output logic                                     adc_standby,
   output logic                                     adc_dc_bypass,
   output logic                                     adc_clock_gate,
   output logic                                     clock_out_disable,
   output logic [1:0]                               output_clock_divider,
   output logic [2:0]                               modulator_rate_band,
   output logic [1:0]                               converter_rate_band,
   output logic                                     modulator_source_select,
   output logic [7:0]                               general_config_out,
   output logic [15:0]                              driver_word,
   output logic                                     bridge_tristate
);
   import codec_regs_pkg::*;

   logic       rst_meta_reg;
   logic       rst_n;
   logic [7:0] popfree_reg;
   logic [7:0] adc_cfg_reg;
   logic [7:0] clkout_reg;
   logic [7:0] general_reg;
   logic [7:0] drv_high_reg;
   logic [7:0] drv_low_reg;
   logic [7:0] ftime_high_reg;
   logic [7:0] ftime_low_reg;
   logic [3:0] fault_s1_reg;
   logic [3:0] fault_s2_reg;
   logic [3:0] fault_s3_reg;
   logic [3:0] fault_latch_reg;
   logic [2:0] lock_sync_reg;
   logic       pll_locked_reg;
   logic [2:0] mod_sync_reg [2];
   logic       pdown_s1_reg;
   logic       pdown_s2_reg;
   logic       pdown_s3_reg;
   logic       pdown_reg;
   logic       mod_invalid_reg;
   logic       mod_muted_reg;
   logic       clear_fault;
   logic [3:0] fault_rise;
   logic       hold_active;
   logic [7:0] rdata_next;

   function automatic logic wr_hit(input logic [7:0] addr);
      wr_hit = reg_write && (reg_addr == addr);
   endfunction

   // Reset release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Writable registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         popfree_reg    <= RST_POPFREE_CONTROL;
         adc_cfg_reg    <= RST_ADC_CONFIG;
         clkout_reg     <= RST_CLOCK_OUT_CONFIG;
         general_reg    <= RST_GENERAL_CONFIG;
         drv_high_reg   <= RST_DRIVER_WORD;
         drv_low_reg    <= RST_DRIVER_WORD;
         ftime_high_reg <= RST_FAULT_TIME_HIGH;
         ftime_low_reg  <= RST_FAULT_TIME_LOW;
      end else begin
         if (wr_hit(ADDR_POPFREE_CONTROL))
            popfree_reg <= reg_wdata & MASK_POPFREE_CONTROL;   // [RULE_21]
         if (wr_hit(ADDR_ADC_CONFIG))
            adc_cfg_reg <= reg_wdata & MASK_ADC_CONFIG;        // [RULE_21]
         if (wr_hit(ADDR_CLOCK_OUT_CONFIG))
            clkout_reg <= reg_wdata & MASK_CLOCK_OUT_CONFIG;   // [RULE_21]
         if (wr_hit(ADDR_GENERAL_CONFIG))
            general_reg <= reg_wdata;
         if (wr_hit(ADDR_DRIVER_WORD_HIGH))
            drv_high_reg <= reg_wdata;                         // [RULE_17]
         if (wr_hit(ADDR_DRIVER_WORD_LOW))
            drv_low_reg <= reg_wdata;                          // [RULE_17]
         if (wr_hit(ADDR_FAULT_TIME_HIGH))
            ftime_high_reg <= reg_wdata;
         if (wr_hit(ADDR_FAULT_TIME_LOW))
            ftime_low_reg <= reg_wdata;
      end
   end

   // Clear bit is a write pulse, never stored, so it reads back zero
   assign clear_fault = wr_hit(ADDR_POPFREE_CONTROL) && reg_wdata[BIT_CLEAR_FAULT]; // [RULE_05]

   // Pin inputs: three stages, change accepted when last two agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_sync_reg   <= 3'h0;
         pll_locked_reg  <= 1'b0;
         mod_sync_reg[0] <= 3'h0;
         mod_sync_reg[1] <= 3'h0;
         mod_invalid_reg <= 1'b0;
         mod_muted_reg   <= 1'b0;
         pdown_s1_reg    <= 1'b0;
         pdown_s2_reg    <= 1'b0;
         pdown_s3_reg    <= 1'b0;
         pdown_reg       <= 1'b0;
         fault_s1_reg    <= 4'h0;
         fault_s2_reg    <= 4'h0;
         fault_s3_reg    <= 4'h0;
      end else begin
         lock_sync_reg   <= {lock_sync_reg[1:0], pll_locked};
         if (lock_sync_reg[1] == lock_sync_reg[2])
            pll_locked_reg <= lock_sync_reg[2];
         mod_sync_reg[0] <= {mod_sync_reg[0][1:0], modulator_invalid};
         mod_sync_reg[1] <= {mod_sync_reg[1][1:0], modulator_muted};
         if (mod_sync_reg[0][1] == mod_sync_reg[0][2])
            mod_invalid_reg <= mod_sync_reg[0][2];
         if (mod_sync_reg[1][1] == mod_sync_reg[1][2])
            mod_muted_reg <= mod_sync_reg[1][2];
         pdown_s1_reg <= bridge_pdown;
         pdown_s2_reg <= pdown_s1_reg;
         pdown_s3_reg <= pdown_s2_reg;
         if (pdown_s2_reg == pdown_s3_reg)
            pdown_reg <= pdown_s3_reg;
         fault_s1_reg <= bridge_fault_in;
         fault_s2_reg <= fault_s1_reg;
         fault_s3_reg <= fault_s2_reg;
      end
   end

   // Accepted fault edge: stages two and three agree on high, prior low
   assign fault_rise = fault_s2_reg & fault_s3_reg & ~fault_latch_reg;

   // Latched faults; a new fault wins over a simultaneous clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_latch_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (fault_s2_reg[i] && fault_s3_reg[i])
               fault_latch_reg[i] <= 1'b1;                     // [RULE_19]
            else if (clear_fault)
               fault_latch_reg[i] <= 1'b0;                     // [RULE_05]
         end
      end
   end

   fault_hold_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_fault_hold (
      .clk         (clk),
      .rst_n       (rst_n),
      .fault_event (|fault_rise),
      .hold_units  ({ftime_high_reg, ftime_low_reg}),
      .hold_active (hold_active)
   );

   // Control outputs
   assign pll_bypass            = popfree_reg[BIT_BYPASS_UNLOCKED] & ~pll_locked_reg; // [RULE_01]
   assign bitclock_as_reference = popfree_reg[BIT_BITCLK_REF];                        // [RULE_02]
   assign synth_power_down      = popfree_reg[BIT_SYNTH_PDOWN];                       // [RULE_03]
   assign pop_guard             = popfree_reg[BIT_POP_GUARD_HI:BIT_POP_GUARD_LO];     // [RULE_04]
   assign adc_gain_select       = adc_cfg_reg[BIT_GAIN_HI:BIT_GAIN_LO];               // [RULE_08]
   assign adc_input_select      = adc_cfg_reg[BIT_INPUT_SELECT];                      // [RULE_09]
   assign adc_standby           = adc_cfg_reg[BIT_ADC_STANDBY];                       // [RULE_10]
   assign adc_dc_bypass         = adc_cfg_reg[BIT_DC_BYPASS];
   assign adc_clock_gate        = adc_cfg_reg[BIT_ADC_CLOCK_GATE];                    // [RULE_11]
   assign clock_out_disable     = clkout_reg[BIT_CLKOUT_DISABLE];
   assign output_clock_divider  = clkout_reg[BIT_CLKOUT_DIV_HI:BIT_CLKOUT_DIV_LO];    // [RULE_12]
   assign modulator_rate_band   = general_reg[BIT_MOD_RATE_HI:BIT_MOD_RATE_LO];       // [RULE_13]
   assign converter_rate_band   = general_reg[BIT_ADC_RATE_HI:BIT_ADC_RATE_LO];       // [RULE_14]
   assign modulator_source_select = general_reg[BIT_MOD_SOURCE];                      // [RULE_15]
   assign general_config_out    = general_reg;
   assign driver_word           = {drv_high_reg, drv_low_reg};                        // [RULE_17]
   // Tristate while any fault stays latched, and while the hold timer runs after a fault edge
   assign bridge_tristate       = hold_active | (|fault_latch_reg);                   // [RULE_20]

   // Read mux: status is live and reading changes nothing
   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr)
         ADDR_POPFREE_CONTROL:  rdata_next = popfree_reg;
         ADDR_PLL_STATUS:       rdata_next = {~pll_locked_reg, synth_power_down,
                                              pll_bypass, 5'h00};      // [RULE_06] [RULE_07]
         ADDR_ADC_CONFIG:       rdata_next = adc_cfg_reg;
         ADDR_CLOCK_OUT_CONFIG: rdata_next = clkout_reg;
         ADDR_GENERAL_CONFIG:   rdata_next = general_reg;
         ADDR_MODULATOR_STATUS: rdata_next = {5'h00, mod_invalid_reg,
                                              mod_muted_reg, 1'b0};    // [RULE_16] [RULE_22]
         ADDR_DRIVER_WORD_HIGH: rdata_next = drv_high_reg;
         ADDR_DRIVER_WORD_LOW:  rdata_next = drv_low_reg;
         ADDR_FAULT_TIME_HIGH:  rdata_next = ftime_high_reg;
         ADDR_FAULT_TIME_LOW:   rdata_next = ftime_low_reg;
         ADDR_BRIDGE_STATUS:    rdata_next = {pdown_reg, bridge_tristate,
                                              fault_latch_reg, 2'b00}; // [RULE_18] [RULE_19]
         default:               rdata_next = 8'h00;                   // [RULE_21]
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read)
            reg_rdata <= rdata_next;                                 // [RULE_22]
      end
   end

   sequence s_fault_seen;
      !(&fault_latch_reg) ##1 (fault_s2_reg != 4'h0 && fault_s3_reg == fault_s2_reg);
   endsequence

   a_bypass_unlock: assert property (@(posedge clk) disable iff (!rst_n)
      pll_bypass == (popfree_reg[BIT_BYPASS_UNLOCKED] && !pll_locked_reg)) // [RULE_01]
      else $error("bypass mismatch");
   a_clear_stored: assert property (@(posedge clk) disable iff (!rst_n)
      wr_hit(ADDR_POPFREE_CONTROL) |=> !popfree_reg[BIT_CLEAR_FAULT]) // [RULE_05]
      else $error("clear bit stored");
   a_fault_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (clear_fault && !(|(fault_s2_reg & fault_s3_reg))) |=> fault_latch_reg == 4'h0) // [RULE_05]
      else $error("fault not cleared");
   a_fault_latch: assert property (@(posedge clk) disable iff (!rst_n)
      s_fault_seen |=> ((fault_latch_reg & fault_s3_reg) == $past(fault_s3_reg))) // [RULE_19]
      else $error("fault not latched");
   a_fault_tristate: assert property (@(posedge clk) disable iff (!rst_n)
      |fault_latch_reg |-> bridge_tristate) // [RULE_20]
      else $error("no tristate on fault");
   a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_read && reg_addr == ADDR_PLL_STATUS) |=>
         reg_rvalid && reg_rdata[4:0] == 5'h00 && reg_rdata[7] == $past(~pll_locked_reg)) // [RULE_06]
      else $error("pll status read wrong");
   a_gain_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_hit(ADDR_ADC_CONFIG) |=> adc_gain_select == $past(reg_wdata[7:5])) // [RULE_08]
      else $error("gain not written");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      clkout_reg[4:0] == 5'h00 && adc_cfg_reg[0] == 1'b0) // [RULE_21]
      else $error("reserved bit set");
   a_driver_word: assert property (@(posedge clk) disable iff (!rst_n)
      wr_hit(ADDR_DRIVER_WORD_HIGH) |=> driver_word[15:8] == $past(reg_wdata)) // [RULE_17]
      else $error("driver word high wrong");
endmodule

// ==== rtl/codec_regs_pkg.sv ====
/*
 Register map, field positions, reset values and timing constants
 for the codec configuration and status register bank.
 Assumes an 8-bit register address and 8-bit data path.
*/
package codec_regs_pkg;
   localparam int          ADDR_W                = 8;
   localparam int          DATA_W                = 8;
   localparam logic [7:0]  ADDR_POPFREE_CONTROL  = 8'h18;
   localparam logic [7:0]  ADDR_PLL_STATUS       = 8'h19;
   localparam logic [7:0]  ADDR_ADC_CONFIG       = 8'h1e;
   localparam logic [7:0]  ADDR_CLOCK_OUT_CONFIG = 8'h1f;
   localparam logic [7:0]  ADDR_GENERAL_CONFIG   = 8'h20;
   localparam logic [7:0]  ADDR_MODULATOR_STATUS = 8'h23;
   localparam logic [7:0]  ADDR_DRIVER_WORD_HIGH = 8'h2d;
   localparam logic [7:0]  ADDR_DRIVER_WORD_LOW  = 8'h2e;
   localparam logic [7:0]  ADDR_BRIDGE_STATUS    = 8'h32;
   localparam logic [7:0]  ADDR_FAULT_TIME_HIGH  = 8'h05;
   localparam logic [7:0]  ADDR_FAULT_TIME_LOW   = 8'h06;
   localparam logic [7:0]  RST_POPFREE_CONTROL   = 8'h00;
   localparam logic [7:0]  RST_ADC_CONFIG        = 8'h02;
   localparam logic [7:0]  RST_CLOCK_OUT_CONFIG  = 8'h00;
   localparam logic [7:0]  RST_GENERAL_CONFIG    = 8'h20;
   localparam logic [7:0]  RST_DRIVER_WORD       = 8'h00;
   localparam logic [7:0]  RST_FAULT_TIME_HIGH   = 8'h00;
   localparam logic [7:0]  RST_FAULT_TIME_LOW    = 8'h02;
   localparam logic [7:0]  MASK_POPFREE_CONTROL  = 8'hfe;
   localparam logic [7:0]  MASK_ADC_CONFIG       = 8'hfe;
   localparam logic [7:0]  MASK_CLOCK_OUT_CONFIG = 8'he0;
   localparam int          BIT_BYPASS_UNLOCKED   = 7;
   localparam int          BIT_BITCLK_REF        = 6;
   localparam int          BIT_SYNTH_PDOWN       = 5;
   localparam int          BIT_POP_GUARD_HI      = 4;
   localparam int          BIT_POP_GUARD_LO      = 1;
   localparam int          BIT_CLEAR_FAULT       = 0;
   localparam int          BIT_GAIN_HI           = 7;
   localparam int          BIT_GAIN_LO           = 5;
   localparam int          BIT_INPUT_SELECT      = 4;
   localparam int          BIT_ADC_STANDBY       = 3;
   localparam int          BIT_DC_BYPASS         = 2;
   localparam int          BIT_ADC_CLOCK_GATE    = 1;
   localparam int          BIT_CLKOUT_DISABLE    = 7;
   localparam int          BIT_CLKOUT_DIV_HI     = 6;
   localparam int          BIT_CLKOUT_DIV_LO     = 5;
   localparam int          BIT_MOD_RATE_HI       = 6;
   localparam int          BIT_MOD_RATE_LO       = 4;
   localparam int          BIT_ADC_RATE_HI       = 3;
   localparam int          BIT_ADC_RATE_LO       = 2;
   localparam int          BIT_MOD_SOURCE        = 1;
   localparam int          CLK_HZ                = 40_000_000;
   localparam real         FAULT_UNIT_US         = 83.33;
   localparam int          FAULT_UNIT_CYCLES     = int'(FAULT_UNIT_US * real'(CLK_HZ) / 1.0e6);
endpackage

// ==== rtl/fault_hold_timer.sv ====
/*
 Fault hold timer: on a fault event, holds the bridge tristated for
 hold_units times one unit period. Assumes one clock, synchronous events.
*/
`timescale 1ns/1ps
module fault_hold_timer #(
   parameter int UNIT_CYCLES = codec_regs_pkg::FAULT_UNIT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        fault_event,
   input  wire logic [15:0] hold_units,
   output logic             hold_active
);
   import codec_regs_pkg::*;
   logic [15:0] unit_reg;
   logic [15:0] units_left_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_reg       <= 16'h0000;
         units_left_reg <= 16'h0000;
      end else if (fault_event) begin
         // Retrigger restarts the full hold period
         unit_reg       <= 16'h0000;
         units_left_reg <= hold_units;
      end else if (units_left_reg != 16'h0000) begin
         if (unit_reg == 16'(UNIT_CYCLES - 1)) begin
            unit_reg       <= 16'h0000;
            units_left_reg <= units_left_reg - 16'h0001;
         end else begin
            unit_reg <= unit_reg + 16'h0001;
         end
      end
   end

   assign hold_active = (units_left_reg != 16'h0000);
endmodule
